// *** include/rof_pkg.sv ***
// package: constants and types for the receive output formatter
package rof_pkg;
	localparam int CHAN_N = 2; // receive channels
	localparam int FIFO_DEPTH = 8; // characters buffered per channel
	localparam int CHAR_W = 21; // raw + decoded byte + decoded status
	localparam int MODE_N = 9; // transmit operating modes
	localparam logic [3:0] LVL_COUNT = 4'h3; // levels per three-level input
	localparam logic [MODE_N-1:0] TX_MODE_RESET = 9'h010; // both selects at mid
	localparam logic [7:0] ADDR_CTRL = 8'h00; // control word, read/write
	localparam logic [7:0] ADDR_STATUS = 8'h04; // status word, read only
	localparam int CTRL_RUN_BIT = 0; // output register may advance
	localparam logic CTRL_RUN_RESET = 1'b1;
	localparam int ST_MODE_LSB = 0; // one-hot transmit mode
	localparam int ST_DEC_LSB = 12; // resolved decoder select
	localparam int ST_CKS_LSB = 14; // resolved clock source select
	localparam int ST_FIFO_LSB = 16; // per channel buffer not empty
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] PIN_HIGH = 2'h2; // {pulled high, pulled low}
	localparam logic [1:0] PIN_LOW = 2'h1;
	localparam logic [6:0] COMMA_POS = 7'h1F; // first seven bits of a comma
	localparam logic [6:0] COMMA_NEG = 7'h60;
	// resolved three-level input
	typedef enum logic [1:0] {LVL_LOW = 2'h0, LVL_MID = 2'h1, LVL_HIGH = 2'h2} rof_level_type;
	// one received character as the deserializer delivers it
	typedef struct packed {
		logic [9:0] raw; // raw character, bit 9 received first
		logic [7:0] dec_byte; // decoded data or special code
		logic [2:0] dec_stat; // decoder status
	} rof_char_type;
	// one channel of the parallel output register
	typedef struct packed {
		logic [7:0] data;
		logic [2:0] stat;
	} rof_out_type;
	// state of the formatter outside its character buffers
	typedef struct packed {
		logic [7:0] tern_s1; // three-level pins, first stage
		logic [7:0] tern_s2; // three-level pins, second stage
		logic [2:0] rec_s; // recovered clock: two stages and last
		logic [2:0] ref_s; // reference clock: two stages and last
		rof_out_type [CHAN_N-1:0] outq; // output register
		logic clk_out; // interface clock strobe
		logic [MODE_N-1:0] tx_mode; // decoded transmit mode
		logic run; // control bit
		logic aw_got; // write address held
		logic w_got; // write data held
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rof_state_type;
endpackage : rof_pkg

// *** verilog/rof_formatter.sv ***
// Function
// [RULE_01] two three-level selects give nine transmit modes
// [RULE_02] data outputs change only after selected edge
// [RULE_03] status outputs change with data, same edge
// [RULE_04] decoder on: data shows decoded byte
// [RULE_05] decoder on: status reports shown character
// [RULE_06] bypass: data shows raw bits nine to two
// [RULE_07] bypass: status low bits are raw low bits
// [RULE_08] bypass: status bit two flags comma
// [RULE_09] floating three-level input resolves to mid
// [RULE_10] clock source mid uses recovered clock
`timescale 1ns/1ns

// character buffer between deserializer and output register
module rof_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	// storage, pointers and fill count
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} rof_fifo_state_type;
	rof_fifo_state_type q; // registered state
	rof_fifo_state_type d; // next state
	logic push; // word taken in
	logic pop; // word handed out

	assign in_ready = q.cnt != (AW+1)'(DEPTH);
	assign out_valid = q.cnt != '0;
	assign out_data = q.mem[q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer and count update
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = AW'(q.wp + 1'b1);
		end
		if (pop) begin
			d.rp = AW'(q.rp + 1'b1);
		end
		d.cnt = (AW+1)'(q.cnt + push - pop);
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : rof_fifo

// receive output formatter for two channels
module rof_formatter
	import rof_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] decoder_select,
	input wire logic [1:0] rx_clock_source_select,
	input wire logic [3:0] transmit_operating_select,
	input wire logic recovered_clock_in,
	input wire logic reference_clock_in,
	input wire rof_char_type [CHAN_N-1:0] char_in,
	input wire logic [CHAN_N-1:0] char_in_valid,
	output logic [CHAN_N-1:0] char_in_ready,
	output logic [7:0] rx_parallel_out_chan_a,
	output logic [7:0] rx_parallel_out_chan_b,
	output logic [2:0] rx_status_out_chan_a,
	output logic [2:0] rx_status_out_chan_b,
	output logic receive_interface_clock_out,
	output logic [MODE_N-1:0] transmit_mode
);
	rof_state_type q; // registered state
	rof_state_type d; // next state
	rof_level_type dec_lvl; // resolved decoder select
	rof_level_type cks_lvl; // resolved clock source select
	rof_level_type tx_hi; // resolved transmit select, upper input
	rof_level_type tx_lo; // resolved transmit select, lower input
	logic [3:0] mode_idx; // transmit mode number
	logic rec_tick; // recovered clock rising edge
	logic ref_tick; // reference clock rising edge
	logic sel_tick; // selected interface clock edge
	logic [CHAN_N-1:0] buf_valid; // buffer holds a character
	logic [CHAN_N-1:0] pop; // output register loads
	rof_char_type [CHAN_N-1:0] buf_data; // head of each buffer
	logic [31:0] status_word; // status read value

	// pin pair {pulled high, pulled low}; neither pulled floats to mid
	function automatic rof_level_type resolve(input logic [1:0] pin);
		rof_level_type lvl;
		lvl = LVL_MID;
		case (pin)
			PIN_HIGH: lvl = LVL_HIGH;
			PIN_LOW: lvl = LVL_LOW;
			default: lvl = LVL_MID; // open or contended [RULE_09]
		endcase
		return lvl;
	endfunction : resolve

	// shape one buffered character for the output register
	function automatic rof_out_type shape(input rof_char_type c, input rof_level_type dec);
		rof_out_type o;
		o = '0;
		if (dec != LVL_LOW) begin
			o.data = c.dec_byte; // [RULE_04]
			o.stat = c.dec_stat; // [RULE_05]
		end else begin
			o.data = c.raw[9:2]; // [RULE_06]
			o.stat[1:0] = c.raw[1:0]; // [RULE_07]
			o.stat[2] = (c.raw[9:3] == COMMA_POS) || (c.raw[9:3] == COMMA_NEG); // [RULE_08]
		end
		return o;
	endfunction : shape

	// resolved selects come from the second sync stage only
	assign dec_lvl = resolve(q.tern_s2[1:0]);
	assign cks_lvl = resolve(q.tern_s2[3:2]);
	assign tx_lo = resolve(q.tern_s2[5:4]);
	assign tx_hi = resolve(q.tern_s2[7:6]);
	assign mode_idx = {2'h0, tx_hi} * LVL_COUNT + {2'h0, tx_lo}; // [RULE_01]

	// edges seen on the synchronised clock pins
	assign rec_tick = q.rec_s[1] && !q.rec_s[2];
	assign ref_tick = q.ref_s[1] && !q.ref_s[2];
	// low picks the reference clock, mid and high the recovered one
	assign sel_tick = (cks_lvl == LVL_LOW) ? ref_tick : rec_tick; // [RULE_10]

	// one buffer per channel; drain stalls until the selected edge
	for (genvar ch = 0; ch < CHAN_N; ch++) begin : g_chan
		assign pop[ch] = buf_valid[ch] && sel_tick && q.run; // [RULE_02]
		rof_fifo #(
			.WIDTH(CHAR_W),
			.DEPTH(FIFO_DEPTH)
		) u_fifo (
			.aclk(aclk),
			.aresetn(aresetn),
			.in_valid(char_in_valid[ch]),
			.in_ready(char_in_ready[ch]),
			.in_data(char_in[ch]),
			.out_valid(buf_valid[ch]),
			.out_ready(pop[ch]),
			.out_data(buf_data[ch])
		);
	end

	// status word layout
	always_comb begin
		status_word = '0;
		status_word[ST_MODE_LSB +: MODE_N] = q.tx_mode;
		status_word[ST_DEC_LSB +: 2] = dec_lvl;
		status_word[ST_CKS_LSB +: 2] = cks_lvl;
		status_word[ST_FIFO_LSB +: CHAN_N] = buf_valid;
	end

	// bus handshakes: one write and one read in flight
	assign s_axi_awready = !q.aw_got && !q.bvalid;
	assign s_axi_wready = !q.w_got && !q.bvalid;
	assign s_axi_arready = !q.rvalid;

	// next state of the formatter outside its character buffers
	always_comb begin
		d = q;
		// pin synchronisers
		d.tern_s1 = {transmit_operating_select, rx_clock_source_select, decoder_select};
		d.tern_s2 = q.tern_s1;
		d.rec_s = {q.rec_s[1:0], recovered_clock_in};
		d.ref_s = {q.ref_s[1:0], reference_clock_in};
		// one-hot transmit mode
		d.tx_mode = '0;
		d.tx_mode[mode_idx] = 1'b1; // [RULE_01]
		// strobe marks the cycle new outputs appear
		d.clk_out = sel_tick && q.run;
		// output register, data and status together
		for (int ch = 0; ch < CHAN_N; ch++) begin
			if (pop[ch]) begin
				d.outq[ch] = shape(buf_data[ch], dec_lvl); // [RULE_02] [RULE_03]
			end
		end
		// write response retires
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		// write address and data captured in either order
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		// both halves present: perform the write
		if (d.aw_got && d.w_got && !q.bvalid) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			if (d.awaddr == ADDR_CTRL) begin
				d.bresp = RESP_OKAY;
				if (d.wstrb[0]) begin
					d.run = d.wdata[CTRL_RUN_BIT];
				end
			end else begin
				d.bresp = RESP_SLVERR; // status and unmapped
			end
		end
		// read response retires
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		// read address taken
		if (s_axi_arvalid && s_axi_arready) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CTRL: d.rdata = {31'h0, q.run};
				ADDR_STATUS: d.rdata = status_word;
				default: begin
					d.rdata = '0;
					d.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.run <= CTRL_RUN_RESET;
			q.tx_mode <= TX_MODE_RESET;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flip-flops
	assign rx_parallel_out_chan_a = q.outq[0].data;
	assign rx_parallel_out_chan_b = q.outq[1].data;
	assign rx_status_out_chan_a = q.outq[0].stat;
	assign rx_status_out_chan_b = q.outq[1].stat;
	assign receive_interface_clock_out = q.clk_out;
	assign transmit_mode = q.tx_mode;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_tx_mode_onehot: assert property ($onehot(q.tx_mode)) // [RULE_01]
		else $error("transmit mode not one-hot");
	chk_tx_mode_map: assert property ((transmit_operating_select == 4'h5) [*4] |-> q.tx_mode == 9'h001) // [RULE_01]
		else $error("both transmit selects low must give mode zero");
	chk_data_on_edge: assert property (!$stable(q.outq[0].data) |-> $past(pop[0]) && $past(sel_tick)) // [RULE_02]
		else $error("data changed without selected edge");
	chk_stat_on_edge: assert property ($changed(q.outq[1].stat) |-> $past(pop[1])) // [RULE_03]
		else $error("status changed without load");
	chk_dec_data: assert property (pop[0] && dec_lvl != LVL_LOW |=> q.outq[0].data == $past(buf_data[0].dec_byte)) // [RULE_04]
		else $error("decoded byte not shown");
	chk_dec_status: assert property (pop[1] && dec_lvl != LVL_LOW |=> q.outq[1].stat == $past(buf_data[1].dec_stat)) // [RULE_05]
		else $error("decoder status not shown");
	chk_bypass_data: assert property (pop[0] && dec_lvl == LVL_LOW |=> q.outq[0].data == $past(buf_data[0].raw[9:2])) // [RULE_06]
		else $error("bypass data not raw upper bits");
	chk_bypass_low: assert property (pop[0] && dec_lvl == LVL_LOW |=> q.outq[0].stat[1:0] == $past(buf_data[0].raw[1:0])) // [RULE_07]
		else $error("bypass status low bits wrong");
	chk_bypass_comma: assert property (pop[0] && dec_lvl == LVL_LOW && buf_data[0].raw[9:3] == COMMA_POS |=> q.outq[0].stat[2]) // [RULE_08]
		else $error("comma not flagged");
	chk_float_mid: assert property ((decoder_select == 2'h0) [*3] |-> dec_lvl == LVL_MID) // [RULE_09]
		else $error("floating select not mid");
	chk_rec_clock: assert property (pop[0] && cks_lvl == LVL_MID |-> rec_tick) // [RULE_10]
		else $error("mid clock select loaded without recovered edge");
endmodule : rof_formatter

// *** bench/rof_host_model.sv ***
// host logic that captures the formatter's parallel outputs
`timescale 1ns/1ns
module rof_host_model
	import rof_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic strobe,
	input wire logic [7:0] data_a,
	input wire logic [7:0] data_b,
	input wire logic [2:0] stat_a,
	input wire logic [2:0] stat_b,
	output rof_out_type [CHAN_N-1:0] cap,
	output int n_strobe,
	output int n_stray
);
	rof_out_type [CHAN_N-1:0] seen; // outputs as shown now
	rof_out_type [CHAN_N-1:0] prev_q; // outputs one cycle ago
	assign seen = {data_b, stat_b, data_a, stat_a};
	// capture mid-cycle, where registered outputs are settled; counters clear in reset
	always @(negedge aclk) begin
		if (!aresetn) begin
			cap <= '0;
			n_strobe <= 0;
			n_stray <= 0;
		end else if (strobe) begin
			cap <= seen;
			n_strobe <= n_strobe + 1;
		end else if (seen !== prev_q) begin
			n_stray <= n_stray + 1; // output moved without an interface edge
		end
		prev_q <= seen;
	end
endmodule : rof_host_model

// *** bench/receive_output_formatting_tb_top.sv ***
// self-checking bench for the receive output formatter
`timescale 1ns/1ns
module receive_output_formatting_tb_top
	import rof_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, recovered_clock_in, reference_clock_in;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rx_parallel_out_chan_a, rx_parallel_out_chan_b;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb, transmit_operating_select;
	logic [1:0] s_axi_bresp, s_axi_rresp, decoder_select, rx_clock_source_select, char_in_valid, char_in_ready, rs;
	logic [2:0] rx_status_out_chan_a, rx_status_out_chan_b;
	logic receive_interface_clock_out, rec_en;
	logic [MODE_N-1:0] transmit_mode;
	rof_char_type [CHAN_N-1:0] char_in;
	rof_out_type [CHAN_N-1:0] cap;
	int n_strobe, n_stray, n_mismatch, total_checks, seed, rc, fc, k;
	logic [1:0] lv [4] = '{2'h1, 2'h0, 2'h2, 2'h3}; // low, floating mid, high, both-pulled mid
	rof_formatter u_rof_formatter (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .decoder_select(decoder_select),
		.rx_clock_source_select(rx_clock_source_select), .transmit_operating_select(transmit_operating_select),
		.recovered_clock_in(recovered_clock_in), .reference_clock_in(reference_clock_in), .char_in(char_in),
		.char_in_valid(char_in_valid), .char_in_ready(char_in_ready),
		.rx_parallel_out_chan_a(rx_parallel_out_chan_a), .rx_parallel_out_chan_b(rx_parallel_out_chan_b),
		.rx_status_out_chan_a(rx_status_out_chan_a), .rx_status_out_chan_b(rx_status_out_chan_b),
		.receive_interface_clock_out(receive_interface_clock_out), .transmit_mode(transmit_mode));
	rof_host_model u_rof_host_model (.aclk(aclk), .aresetn(aresetn), .strobe(receive_interface_clock_out),
		.data_a(rx_parallel_out_chan_a), .data_b(rx_parallel_out_chan_b), .stat_a(rx_status_out_chan_a),
		.stat_b(rx_status_out_chan_b), .cap(cap), .n_strobe(n_strobe), .n_stray(n_stray));
	initial begin
		aclk = 1'b0;
		forever #10 aclk = !aclk;
	end
	// recovered clock 6 cycles, reference 8 cycles
	always @(posedge aclk) begin
		if (!aresetn) begin
			rc <= 0;
			fc <= 0;
			recovered_clock_in <= 1'b0;
			reference_clock_in <= 1'b0;
		end else begin
			rc <= (rc == 2) ? 0 : rc + 1;
			fc <= (fc == 3) ? 0 : fc + 1;
			if (rec_en && rc == 2) recovered_clock_in <= !recovered_clock_in;
			if (fc == 3) reference_clock_in <= !reference_clock_in;
		end
	end
	// numeric level of an lv entry: both pulled counts as mid
	function automatic int lnum(input int j);
		return (j == 3) ? 1 : j;
	endfunction : lnum
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	// one register access; handshakes sampled mid-cycle, released after the taking edge
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, hit;
		@(posedge aclk);
		if (wr) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		hit = 1'b0;
		for (int i = 0; i < 100 && !hit; i++) begin
			@(negedge aclk);
			ta = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
			tw = s_axi_wvalid && s_axi_wready;
			hit = wr ? s_axi_bvalid : s_axi_rvalid;
			rs = wr ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (ta) s_axi_arvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (hit) s_axi_bready <= 1'b0;
			if (hit) s_axi_rready <= 1'b0;
		end
		if (!hit) n_mismatch++; // no answer within the limit
	endtask : axi
	// one character on each channel, each taken on its own handshake
	task automatic push(input rof_char_type ca, input rof_char_type cb);
		logic [1:0] pend;
		@(posedge aclk);
		char_in <= {cb, ca};
		char_in_valid <= 2'h3;
		pend = 2'h3;
		for (int i = 0; i < 20 && pend != 2'h0; i++) begin
			@(negedge aclk);
			pend = pend & ~char_in_ready;
			@(posedge aclk);
			char_in_valid <= pend;
		end
		if (pend != 2'h0) n_mismatch++; // character never taken
	endtask : push
	function automatic rof_out_type exp_out(input rof_char_type c, input logic byp);
		exp_out = {c.dec_byte, c.dec_stat};
		if (byp) exp_out = {c.raw[9:2], (c.raw[9:3] == COMMA_POS) || (c.raw[9:3] == COMMA_NEG), c.raw[1:0]};
	endfunction : exp_out
	// stall, buffer n characters, release and follow each load
	task automatic burst(input int n, input logic byp);
		rof_char_type ca [$];
		rof_char_type cb [$];
		rof_char_type x, y;
		axi(1'b1, ADDR_CTRL, 32'h0);
		chk(rs, RESP_OKAY);
		k = n_strobe;
		for (int i = 0; i < n; i++) begin
			x = 21'($random(seed));
			y = 21'($random(seed));
			if (i < 2) x.raw[9:3] = i ? COMMA_NEG : COMMA_POS; // comma corners
			ca.push_back(x);
			cb.push_back(y);
			push(x, y);
		end
		@(negedge aclk);
		chk(n_strobe, k);
		if (n == FIFO_DEPTH) chk(char_in_ready, 2'h0);
		axi(1'b1, ADDR_CTRL, 32'h1);
		for (int i = 0; i < n; i++) begin
			for (int j = 0; j < 60 && n_strobe < k + i + 1; j++) @(negedge aclk);
			if (n_strobe < k + i + 1) n_mismatch++; // no interface edge within the limit
			chk(cap[0], exp_out(ca[i], byp));
			chk(cap[1], exp_out(cb[i], byp));
		end
	endtask : burst
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		summarize();
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, char_in, char_in_valid} = '0;
		{decoder_select, rx_clock_source_select, transmit_operating_select} = '0;
		s_axi_wstrb = 4'hF;
		rec_en = 1'b1;
		seed = 4;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		axi(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h1);
		axi(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[8:0], TX_MODE_RESET);
		chk(rd, 32'h0000_5010);
		axi(1'b1, ADDR_STATUS, 32'h0);
		chk(rs, RESP_SLVERR);
		axi(1'b0, 8'h08, 32'h0);
		chk(rs, RESP_SLVERR);
		chk(rd, 32'h0);
		for (int i = 0; i < 16; i++) begin
			@(posedge aclk);
			transmit_operating_select <= {lv[i / 4], lv[i % 4]};
			repeat (8) @(posedge aclk);
			chk(transmit_mode, 32'h1 << (3 * lnum(i / 4) + lnum(i % 4)));
		end
		// mid source must ignore a running reference while recovered stands still
		rec_en <= 1'b0;
		repeat (10) @(posedge aclk);
		k = n_strobe;
		repeat (40) @(posedge aclk);
		chk(n_strobe, k);
		rec_en <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge aclk);
			decoder_select <= lv[i];
			rx_clock_source_select <= lv[3 - i];
			repeat (6) @(posedge aclk);
			burst((i == 0 || i == 3) ? FIFO_DEPTH : 4, i == 0);
		end
		chk(n_stray, 0);
		summarize();
	end
endmodule : receive_output_formatting_tb_top
